// ---- rl_state_regs.vh ----
// Constants for the remote/local lockout state controller
`ifndef RL_STATE_REGS_VH
`define RL_STATE_REGS_VH
// One-hot operating state codes
`define ST_LOCAL 4'h1
`define ST_LOCAL_LOCK 4'h2
`define ST_REMOTE 4'h4
`define ST_REMOTE_LOCK 4'h8
// Baud range and default of the target-facing port
`define BAUD_MIN 300
`define BAUD_MAX 9600
`define BAUD_DEFAULT 9600
`define CLK_HZ 10000000
// Frame format: data bits, stop bits
`define FRAME_DATA_BITS 8
`define FRAME_STOP_BITS 1
// Serial command codes from the host parser
`define CMD_NONE 2'h0
`define CMD_REMOTE 2'h1
`define CMD_LOCAL 2'h2
`define CMD_LOCKOUT 2'h3
`endif

// ---- rl_state_ctrl.v ----
// Remote/local lockout state controller with target-port byte sender
`include "rl_state_regs.vh"

module rl_state_ctrl #(
  parameter KEYS = 8,  // Front-panel key lines
  parameter POWER_KEY = 0,  // Index of power switch
  parameter LOCAL_KEY = 1  // Index of go-to-local softkey
) (
  input wire mclk,
  input wire rst,
  input wire [1:0] host_cmd,  // Decoded serial command
  input wire host_cmd_valid,  // One-cycle command strobe
  input wire gtl_msg,  // Go-to-local bus message pulse
  input wire llo_msg,  // Local-lockout bus message pulse
  input wire my_listen_addr,  // Addressed as listener pulse
  input wire remote_enable,  // Bus remote-enable pin, asynchronous
  input wire [KEYS-1:0] panel_keys,  // Raw key pulses from panel scan
  output reg [KEYS-1:0] keys_allowed,  // Keys passed to the instrument
  output reg [3:0] op_state,  // One-hot operating state
  output wire cmds_allowed,  // Remote commands execute
  input wire [15:0] baud_sel,  // Selected baud for target port
  input wire [7:0] pass_byte,  // Pass-through byte
  input wire pass_valid,  // Pass-through byte offered
  output wire pass_ready,  // Sender accepts byte
  output reg uut_txd,  // Target port transmit line
  output wire uut_is_dce,  // Target port role
  output wire host_is_dte  // Host port role
);

  ////////////////////////////////////////////////////////////////////
  // Remote-enable synchroniser
  reg ren_meta;  // First stage, read only by second
  reg ren_sync;  // Usable level
  reg ren_prev;  // Last cycle's usable level, for the falling edge
  // Two flops plus edge history, all cleared to the idle-low level
  always @(posedge mclk) begin
    if (rst) begin
      ren_meta <= 1'b0;
      ren_sync <= 1'b0;
      ren_prev <= 1'b0;
    end else begin
      ren_meta <= remote_enable;
      ren_sync <= ren_meta;
      ren_prev <= ren_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Event decode
  wire cmd_remote = host_cmd_valid && (host_cmd == `CMD_REMOTE);
  wire cmd_local = host_cmd_valid && (host_cmd == `CMD_LOCAL);
  wire cmd_lock = host_cmd_valid && (host_cmd == `CMD_LOCKOUT);
  wire go_remote = cmd_remote || (ren_sync && my_listen_addr);
  // REN falling is the release event: a host on the serial port never raises
  // REN, so the low level alone must not undo a serial REMOTE command
  wire ren_low = ren_prev && !ren_sync;
  wire softkey_local = panel_keys[LOCAL_KEY];
  wire lock_req = cmd_lock || llo_msg;

  ////////////////////////////////////////////////////////////////////
  // State transition logic
  reg [3:0] next_op_state;
  always @* begin
    next_op_state = op_state;
    case (op_state)
      `ST_LOCAL: begin
        if (lock_req) begin
          next_op_state = `ST_LOCAL_LOCK;
        end else if (go_remote) begin
          next_op_state = `ST_REMOTE;
        end
      end
      `ST_LOCAL_LOCK: begin
        if (cmd_local || (ren_low && !cmd_remote)) begin
          next_op_state = `ST_LOCAL;
        end else if (go_remote) begin
          next_op_state = `ST_REMOTE_LOCK;
        end
      end
      `ST_REMOTE: begin
        if (softkey_local || cmd_local || gtl_msg || (ren_low && !cmd_remote)) begin
          next_op_state = `ST_LOCAL;
        end else if (lock_req) begin
          next_op_state = `ST_REMOTE_LOCK;
        end
      end
      `ST_REMOTE_LOCK: begin
        if (cmd_local || (ren_low && !cmd_remote)) begin
          next_op_state = `ST_LOCAL;
        end else if (gtl_msg) begin
          next_op_state = `ST_LOCAL_LOCK;
        end
      end
      default: begin
        next_op_state = `ST_LOCAL;
      end
    endcase
  end

  // State register
  always @(posedge mclk) begin
    if (rst) begin
      op_state <= `ST_LOCAL;
    end else begin
      op_state <= next_op_state;
    end
  end

  // Remote commands always execute
  assign cmds_allowed = 1'b1;

  ////////////////////////////////////////////////////////////////////
  // Front-panel key gating
  localparam [KEYS-1:0] ONE_KEY = {{(KEYS-1){1'b0}}, 1'b1};  // Bit zero alone
  localparam [KEYS-1:0] POWER_MASK = ONE_KEY << POWER_KEY;  // Power switch
  localparam [KEYS-1:0] LOCAL_MASK = ONE_KEY << LOCAL_KEY;  // Go-to-local softkey

  // Keys each operating state lets through
  function [KEYS-1:0] key_mask;
    input [3:0] state;  // One-hot operating state
    begin
      case (state)
        `ST_REMOTE: begin
          key_mask = POWER_MASK | LOCAL_MASK;
        end
        `ST_REMOTE_LOCK: begin
          key_mask = POWER_MASK;
        end
        default: begin
          key_mask = {KEYS{1'b1}};
        end
      endcase
    end
  endfunction

  // Registered gate; a key press lands one cycle after its scan pulse
  always @(posedge mclk) begin
    if (rst) begin
      keys_allowed <= {KEYS{1'b0}};  // Nothing passes during reset
    end else begin
      keys_allowed <= panel_keys & key_mask(op_state);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Port roles
  // Fixed by the connectors: host side needs a null-modem cable, target side not
  assign host_is_dte = 1'b1;
  assign uut_is_dce = 1'b1;

  ////////////////////////////////////////////////////////////////////
  // Target-port sender, 8N1, one byte at a time in arrival order
  reg [15:0] baud_now;  // Baud in range, else default
  reg [15:0] bit_cnt;  // Cycles left in current bit
  reg [15:0] bit_len;  // Cycles per bit at current baud
  reg [9:0] shifter;  // Stop, data, start
  reg [3:0] bits_left;  // Bits still to send
  wire [31:0] bit_cycles;  // Cycles per bit, full width of the divide
  wire busy = (bits_left != 4'h0);
  // Frame length and fallback rate at full width, trimmed where used
  localparam [31:0] FRAME_LEN = `FRAME_DATA_BITS + `FRAME_STOP_BITS + 1;  // Start, data, stop
  localparam [31:0] BAUD_DEF = `BAUD_DEFAULT;  // Rate for out-of-range selections
  // Lowest rate gives the longest bit, which still fits sixteen bits
  assign bit_cycles = `CLK_HZ / baud_now;
  assign pass_ready = !busy;

  // Pass an in-range baud through, use the default when out of range
  always @* begin
    if (baud_sel < `BAUD_MIN || baud_sel > `BAUD_MAX) begin
      baud_now = BAUD_DEF[15:0];
    end else begin
      baud_now = baud_sel;
    end
  end

  // Serialiser: start bit goes out on the accepting edge, then data LSB first,
  // one stop bit, and ready returns only after the stop bit has had its time.
  // The rate is latched per byte, so a baud change mid-frame waits for the
  // next byte rather than bending the bit in flight.
  always @(posedge mclk) begin
    if (rst) begin
      uut_txd <= 1'b1;
      bit_cnt <= 16'h0000;
      bit_len <= 16'h0000;
      shifter <= 10'h3ff;
      bits_left <= 4'h0;
    end else if (!busy) begin
      uut_txd <= 1'b1;
      if (pass_valid) begin
        bit_len <= bit_cycles[15:0];
        bit_cnt <= bit_cycles[15:0] - 16'h0001;
        shifter <= {1'b1, pass_byte, 1'b0};
        bits_left <= FRAME_LEN[3:0];
        uut_txd <= 1'b0;
      end
    end else if (bit_cnt == 16'h0000) begin
      shifter <= {1'b1, shifter[9:1]};
      bits_left <= bits_left - 4'h1;
      bit_cnt <= bit_len - 16'h0001;
      uut_txd <= (bits_left == 4'h1) ? 1'b1 : shifter[1];
    end else begin
      bit_cnt <= bit_cnt - 16'h0001;
    end
  end

endmodule

// ---- rl_monitor.sv ----
// Checker for the remote/local state controller ports
`include "rl_state_regs.vh"
module rl_monitor #(parameter KEYS = 8) (
  input wire mclk,
  input wire rst,
  input wire [KEYS-1:0] panel_keys,
  input wire [KEYS-1:0] keys_allowed,
  input wire [3:0] op_state,
  input wire llo_msg,
  input wire gtl_msg,
  input wire pass_valid,
  input wire pass_ready,
  input wire uut_txd
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_one; $onehot(op_state); endproperty
  a_one: assert property (p_one) else $error("state not one-hot");
  property p_rst; disable iff (1'b0) rst |=> op_state == `ST_LOCAL && uut_txd; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_loc; op_state == `ST_LOCAL |=> keys_allowed == $past(panel_keys); endproperty
  a_loc: assert property (p_loc) else $error("local keys");
  property p_rem; op_state == `ST_REMOTE |=> keys_allowed == ($past(panel_keys) & 3); endproperty
  a_rem: assert property (p_rem) else $error("remote keys");
  property p_rlk; op_state == `ST_REMOTE_LOCK |=> keys_allowed == ($past(panel_keys) & 1);
  endproperty
  a_rlk: assert property (p_rlk) else $error("lockout keys");
  property p_llo; op_state == `ST_LOCAL && llo_msg |=> op_state == `ST_LOCAL_LOCK; endproperty
  a_llo: assert property (p_llo) else $error("lockout missed");
  property p_gtl; op_state == `ST_REMOTE && gtl_msg |=> op_state == `ST_LOCAL; endproperty
  a_gtl: assert property (p_gtl) else $error("go local missed");
  property p_tx; pass_valid && pass_ready |=> !uut_txd && !pass_ready; endproperty
  a_tx: assert property (p_tx) else $error("no start bit");
endmodule
bind rl_state_ctrl rl_monitor #(.KEYS(KEYS)) mon (.mclk(mclk), .rst(rst),
  .panel_keys(panel_keys), .keys_allowed(keys_allowed), .op_state(op_state),
  .llo_msg(llo_msg), .gtl_msg(gtl_msg), .pass_valid(pass_valid),
  .pass_ready(pass_ready), .uut_txd(uut_txd));

// ---- uart_sink.sv ----
// Serial receiver model standing for the unit under test
module uart_sink (
  input wire mclk,
  input wire rxd,
  input int bit_len,
  output logic [7:0] data,
  output logic stop_ok,
  output int count
);
  timeunit 1ns;
  timeprecision 1ns;
  // Mid-bit sampling, LSB first, stop bit last; bit length read before each bit
  initial begin
    count = 0;
    forever begin
      @(negedge rxd);
      repeat (bit_len / 2) @(posedge mclk);
      repeat (9) begin
        repeat (bit_len) @(posedge mclk);
        {stop_ok, data} = {rxd, stop_ok, data[7:1]};
      end
      count++;
    end
  end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the remote/local state controller
`include "rl_state_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, hv = 0, gtl = 0, llo = 0, lis = 0, ren = 1, pv = 0;
  logic [1:0] hc = 0;
  logic [15:0] baud = 16'h2580;
  int bit_cyc = `CLK_HZ / `BAUD_DEFAULT;
  logic [7:0] pk = 0, pb = 0, ka, rx;
  logic [3:0] st;
  wire ca, pr, txd, dce, dte, stop_ok;
  int errors = 0, checks = 0, rx_count;
  rl_state_ctrl uut (.mclk(mclk), .rst(rst), .host_cmd(hc), .host_cmd_valid(hv),
    .gtl_msg(gtl), .llo_msg(llo), .my_listen_addr(lis), .remote_enable(ren),
    .panel_keys(pk), .keys_allowed(ka), .op_state(st), .cmds_allowed(ca),
    .baud_sel(baud), .pass_byte(pb), .pass_valid(pv), .pass_ready(pr),
    .uut_txd(txd), .uut_is_dce(dce), .host_is_dte(dte));
  uart_sink sink (.mclk(mclk), .rxd(txd), .bit_len(bit_cyc), .data(rx),
    .stop_ok(stop_ok), .count(rx_count));
  initial forever #50 mclk = ~mclk;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One-cycle event: llo, gtl, listen, cmd valid, cmd code
  task ev(input logic [5:0] v, input logic [3:0] exp);
    {llo, gtl, lis, hv, hc} = v;
    @(posedge mclk);
    #1 {llo, gtl, lis, hv, hc} = 0;
    chk(st, exp);
  endtask
  task kp(input logic [7:0] exp);
    pk = 8'hff;
    @(posedge mclk);
    #1 pk = 0;
    chk(ka, exp);
  endtask
  task ren_to(input logic v);
    ren = v;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task t_modes;
    chk(st, `ST_LOCAL);
    chk({ca, dce, dte}, 3'h7);
    kp(8'hff);
    ev(6'h05, `ST_REMOTE);
    kp(8'h03);
    chk(st, `ST_LOCAL);
    ev(6'h08, `ST_REMOTE);
    ev(6'h07, `ST_REMOTE_LOCK);
    kp(8'h01);
    ev(6'h10, `ST_LOCAL_LOCK);
    ev(6'h05, `ST_REMOTE_LOCK);
    ev(6'h06, `ST_LOCAL);
    ev(6'h20, `ST_LOCAL_LOCK);
    ren_to(0);
    chk(st, `ST_LOCAL);
    ren_to(1);
    ev(6'h08, `ST_REMOTE);
    ev(6'h10, `ST_LOCAL);
    ev(6'h08, `ST_REMOTE);
    ren_to(0);
    chk(st, `ST_LOCAL);
    ev(6'h05, `ST_REMOTE);
    ev(6'h00, `ST_REMOTE);
    ev(6'h07, `ST_REMOTE_LOCK);
    ren_to(1);
    ren_to(0);
    chk(st, `ST_LOCAL);
    ren_to(1);
  endtask
  task t_reset;
    ev(6'h08, `ST_REMOTE);
    rst = 1;
    @(posedge mclk);
    #1 rst = 0;
    chk(st, `ST_LOCAL);
    chk({ka, txd, pr}, 10'h003);
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task send(input logic [7:0] b, input logic [15:0] bd, input int cyc);
    int n;
    n = rx_count;
    repeat (1100) if (!pr) begin @(posedge mclk); #1; end
    if (pr !== 1'b1) begin errors++; test_done; end
    baud = bd;
    bit_cyc = cyc;
    pb = b;
    pv = 1;
    @(posedge mclk);
    #1 pv = 0;
    repeat (25000) if (rx_count == n) begin @(posedge mclk); #1; end
    if (rx_count == n) begin errors++; test_done; end
    chk(rx, b);
    chk(stop_ok, 1'b1);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    #1 rst = 0;
    t_modes;
    t_reset;
    send(8'h52, 16'h2580, `CLK_HZ / `BAUD_DEFAULT);
    send(8'h0d, 16'h0064, `CLK_HZ / `BAUD_DEFAULT);
    send(8'ha5, 16'h12c0, `CLK_HZ / 4800);
    test_done;
  end
endmodule
